// [scg_params.svh]
`ifndef SCG_PARAMS_SVH
`define SCG_PARAMS_SVH

// ============================================================
// register offsets
`define SCG_AHB1_OFF    8'h50
`define SCG_AHB2_OFF    8'h54
`define SCG_AHB3_OFF    8'h58
`define SCG_APB1_OFF    8'h60
`define SCG_APB2_OFF    8'h64

// ============================================================
// reset values
`define SCG_AHB1_RST    32'h0001_F187
`define SCG_AHB2_RST    32'h0000_0079
`define SCG_AHB3_RST    32'h0000_0003
`define SCG_APB1_RST    32'h1066_481F
`define SCG_APB2_RST    32'hC006_5911

// ============================================================
// writable field masks (implemented bits only)
`define SCG_AHB1_MASK   32'h0001_F187
`define SCG_AHB2_MASK   32'h0000_0079
`define SCG_AHB3_MASK   32'h0000_0003
`define SCG_APB1_MASK   32'h1066_481F
`define SCG_APB2_MASK   32'hC006_5911

// ============================================================
// field positions
`define SCG_RAM0_BIT        16
`define SCG_FLASH_BIT       15
`define SCG_RADIO_RUN_BIT   14
`define SCG_MAC_BIT         13
`define SCG_CHECKSUM_BIT    12
`define SCG_TOUCH_BIT       8
`define SCG_SEC_GATE_BIT    7
`define SCG_RANDOM_BIT      6
`define SCG_HASH_BIT        5
`define SCG_CIPHER_BIT      4
`define SCG_PUBKEY_BIT      3
`define SCG_CAMERA_BIT      0
`define SCG_QUAD_FLASH_BIT  1
`define SCG_PSRAM_BIT       0
`define SCG_PWR_MGMT_BIT    28
`define SCG_RADIO_BIT       31
`define SCG_FILTER_BIT      30

`endif

// [scg_pkg.sv]
package scg_pkg;
    // ============================================================
    // register selector
    typedef enum logic [2:0]
    {
        SCG_SEL_NONE = 3'b000,
        SCG_SEL_AHB1 = 3'b001,
        SCG_SEL_AHB2 = 3'b010,
        SCG_SEL_AHB3 = 3'b011,
        SCG_SEL_APB1 = 3'b100,
        SCG_SEL_APB2 = 3'b101
    } scg_sel_t;
    typedef logic [31:0] scg_word_t;
endpackage

// [scg_clk_gate.sv]
`timescale 1ns/10ps
`default_nettype none
// glitch-free gate: enable latched while the clock is low
module scg_clk_gate
(
    input  wire logic clk_in,
    input  wire logic enable,
    output var  logic clk_out
);
    logic en_latch;

    // ============================================================
    // low-phase latch keeps enable stable through the high phase
    always_latch
    begin
        if (!clk_in)
            en_latch <= enable;
    end

    // and gate passes only the high phase of an enabled clock
    assign clk_out = clk_in & en_latch;
endmodule // scg_clk_gate
`default_nettype wire

// [scg_sleep_gating.sv]
`timescale 1ns/10ps
`default_nettype none
`include "scg_params.svh"
module scg_sleep_gating
#(
    parameter int NGATE = 32
)
(
    input  wire logic               ref_clk,
    input  wire logic               sys_rst,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [3:0]         reg_be,
    input  wire scg_pkg::scg_word_t reg_wdata,
    output var  scg_pkg::scg_word_t reg_rdata,
    output var  logic               reg_err,
    input  wire logic               cpu_sleep,
    input  wire logic [NGATE-1:0]   ahb1_run_en,
    input  wire logic [NGATE-1:0]   ahb2_run_en,
    input  wire logic [NGATE-1:0]   ahb3_run_en,
    input  wire logic [NGATE-1:0]   apb1_run_en,
    input  wire logic [NGATE-1:0]   apb2_run_en,
    output var  logic [NGATE-1:0]   ahb1_clk_out,
    output var  logic [NGATE-1:0]   ahb2_clk_out,
    output var  logic [NGATE-1:0]   ahb3_clk_out,
    output var  logic [NGATE-1:0]   apb1_clk_out,
    output var  logic [NGATE-1:0]   apb2_clk_out
);
    import scg_pkg::*;

    scg_word_t ahb1_reg, ahb1_next;
    scg_word_t ahb2_reg, ahb2_next;
    scg_word_t ahb3_reg, ahb3_next;
    scg_word_t apb1_reg, apb1_next;
    scg_word_t apb2_reg, apb2_next;
    scg_word_t rdata_next;
    logic      err_next;
    scg_sel_t  sel;

    // ============================================================
    // address decode
    function automatic scg_sel_t decode(input logic [7:0] a);
        unique case (a)
            `SCG_AHB1_OFF: decode = SCG_SEL_AHB1;
            `SCG_AHB2_OFF: decode = SCG_SEL_AHB2;
            `SCG_AHB3_OFF: decode = SCG_SEL_AHB3;
            `SCG_APB1_OFF: decode = SCG_SEL_APB1;
            `SCG_APB2_OFF: decode = SCG_SEL_APB2;
            default:       decode = SCG_SEL_NONE;
        endcase
    endfunction

    // byte-lane merge limited to implemented bits
    function automatic scg_word_t merge(input scg_word_t old,
                                        input scg_word_t wd,
                                        input logic [3:0] be,
                                        input scg_word_t msk);
        scg_word_t lanes;
        lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        merge = (old & ~(lanes & msk)) | (wd & lanes & msk);
    endfunction

    assign sel = decode(reg_addr);

    // ============================================================
    // register next values: software only, per byte lane
    always_comb
    begin
        ahb1_next = ahb1_reg;
        ahb2_next = ahb2_reg;
        ahb3_next = ahb3_reg;
        apb1_next = apb1_reg;
        apb2_next = apb2_reg;
        if (reg_wr)
        begin
            unique case (sel)
                SCG_SEL_AHB1: ahb1_next = merge(ahb1_reg, reg_wdata, reg_be,
                                                `SCG_AHB1_MASK);
                SCG_SEL_AHB2: ahb2_next = merge(ahb2_reg, reg_wdata, reg_be,
                                                `SCG_AHB2_MASK);
                SCG_SEL_AHB3: ahb3_next = merge(ahb3_reg, reg_wdata, reg_be,
                                                `SCG_AHB3_MASK);
                SCG_SEL_APB1: apb1_next = merge(apb1_reg, reg_wdata, reg_be,
                                                `SCG_APB1_MASK);
                SCG_SEL_APB2: apb2_next = merge(apb2_reg, reg_wdata, reg_be,
                                                `SCG_APB2_MASK);
                SCG_SEL_NONE: ;
            endcase
        end
    end

    // read mux and unmapped flag
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        err_next   = 1'b0;
        if (reg_rd || reg_wr)
            err_next = (sel == SCG_SEL_NONE);
        if (reg_rd)
        begin
            unique case (sel)
                SCG_SEL_AHB1: rdata_next = ahb1_reg;
                SCG_SEL_AHB2: rdata_next = ahb2_reg;
                SCG_SEL_AHB3: rdata_next = ahb3_reg;
                SCG_SEL_APB1: rdata_next = apb1_reg;
                SCG_SEL_APB2: rdata_next = apb2_reg;
                SCG_SEL_NONE: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // ============================================================
    // state registers
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            ahb1_reg  <= `SCG_AHB1_RST;
            ahb2_reg  <= `SCG_AHB2_RST;
            ahb3_reg  <= `SCG_AHB3_RST;
            apb1_reg  <= `SCG_APB1_RST;
            apb2_reg  <= `SCG_APB2_RST;
            reg_rdata <= 32'h0000_0000;
            reg_err   <= 1'b0;
        end
        else
        begin
            ahb1_reg  <= ahb1_next;
            ahb2_reg  <= ahb2_next;
            ahb3_reg  <= ahb3_next;
            apb1_reg  <= apb1_next;
            apb2_reg  <= apb2_next;
            reg_rdata <= rdata_next;
            reg_err   <= err_next;
        end
    end

    // ============================================================
    // gate enables: sleep bit only counts while asleep
    logic [5*NGATE-1:0] run_all, slp_all, en_all, clk_all;
    assign run_all = {apb2_run_en, apb1_run_en, ahb3_run_en,
                      ahb2_run_en, ahb1_run_en};
    assign slp_all = {apb2_reg[NGATE-1:0], apb1_reg[NGATE-1:0],
                      ahb3_reg[NGATE-1:0], ahb2_reg[NGATE-1:0],
                      ahb1_reg[NGATE-1:0]};
    assign en_all  = run_all & (~{5*NGATE{cpu_sleep}} | slp_all);

    genvar g;
    generate
        for (g = 0; g < 5*NGATE; g++)
        begin : g_gate
            scg_clk_gate u_gate
            (
                .clk_in  (ref_clk),
                .enable  (en_all[g]),
                .clk_out (clk_all[g])
            );
        end
    endgenerate

    assign ahb1_clk_out = clk_all[NGATE-1:0];
    assign ahb2_clk_out = clk_all[2*NGATE-1:NGATE];
    assign ahb3_clk_out = clk_all[3*NGATE-1:2*NGATE];
    assign apb1_clk_out = clk_all[4*NGATE-1:3*NGATE];
    assign apb2_clk_out = clk_all[5*NGATE-1:4*NGATE];

    // ============================================================
    // checks
    property p_reset_ahb2;
        @(posedge ref_clk) sys_rst |=> ahb2_reg == `SCG_AHB2_RST;
    endproperty
    a_reset_ahb2: assert property (p_reset_ahb2)
        else $error("ahb2 reset");

    property p_reset_apb;
        @(posedge ref_clk) sys_rst |=> apb1_reg == `SCG_APB1_RST &&
                                       apb2_reg == `SCG_APB2_RST;
    endproperty
    a_reset_apb: assert property (p_reset_apb)
        else $error("apb reset");

    property p_hold;
        @(posedge ref_clk) disable iff (sys_rst)
        !reg_wr |=> $stable(ahb3_reg) && $stable(apb2_reg);
    endproperty
    a_hold: assert property (p_hold)
        else $error("reg changed unwritten");

    property p_reserved;
        @(posedge ref_clk) disable iff (sys_rst)
        (apb2_reg[3:1] == 3'h0) && (apb1_reg[10:5] == 6'h00);
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved set");

    property p_byte_wr;
        @(posedge ref_clk) disable iff (sys_rst)
        reg_wr && sel == SCG_SEL_AHB3 && reg_be[0]
        |=> ahb3_reg[1:0] == $past(reg_wdata[1:0]);
    endproperty
    a_byte_wr: assert property (p_byte_wr)
        else $error("ahb3 byte write");

    property p_rd_back;
        @(posedge ref_clk) disable iff (sys_rst)
        reg_rd && !reg_wr && sel == SCG_SEL_APB2
        |=> reg_rdata == $past(apb2_reg);
    endproperty
    a_rd_back: assert property (p_rd_back)
        else $error("readback");

    property p_awake_en;
        @(posedge ref_clk) !cpu_sleep |-> en_all == run_all;
    endproperty
    a_awake_en: assert property (p_awake_en)
        else $error("awake gate");

    property p_sleep_off;
        @(posedge ref_clk) disable iff (sys_rst)
        cpu_sleep && !apb2_reg[`SCG_RADIO_BIT] |-> !en_all[4*NGATE+31];
    endproperty
    a_sleep_off: assert property (p_sleep_off)
        else $error("sleep gate");

    property p_unmapped;
        @(posedge ref_clk) disable iff (sys_rst)
        reg_rd && sel == SCG_SEL_NONE |=> reg_err && reg_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped");

    // ahb1 and ahb3 come out of reset at their reset values
    property p_reset_ahb13;
        @(posedge ref_clk) sys_rst |=> ahb1_reg == `SCG_AHB1_RST &&
                                       ahb3_reg == `SCG_AHB3_RST;
    endproperty
    a_reset_ahb13: assert property (p_reset_ahb13)
        else $error("ahb1 or ahb3 reset");

    // reserved ahb2 and ahb3 bits never take a written one
    property p_reserved_ahb;
        @(posedge ref_clk) disable iff (sys_rst)
        ahb2_reg[31:7] == 25'h000_0000 && ahb2_reg[2:1] == 2'h0 &&
        ahb3_reg[31:2] == 30'h0000_0000;
    endproperty
    a_reserved_ahb: assert property (p_reserved_ahb)
        else $error("reserved ahb bit set");

    // registers without a write keep their value
    property p_hold_rest;
        @(posedge ref_clk) disable iff (sys_rst)
        !reg_wr |=> $stable(ahb1_reg) && $stable(ahb2_reg) &&
                    $stable(apb1_reg);
    endproperty
    a_hold_rest: assert property (p_hold_rest)
        else $error("register changed unwritten");

    // a write to an unmapped offset changes nothing and flags it
    property p_unmapped_wr;
        @(posedge ref_clk) disable iff (sys_rst)
        reg_wr && sel == SCG_SEL_NONE
        |=> reg_err && $stable(ahb1_reg) && $stable(ahb2_reg) &&
            $stable(ahb3_reg) && $stable(apb1_reg) && $stable(apb2_reg);
    endproperty
    a_unmapped_wr: assert property (p_unmapped_wr)
        else $error("unmapped write");

    // full-word writes land on the implemented bits only
    property p_word_ahb1;
        @(posedge ref_clk) disable iff (sys_rst)
        reg_wr && sel == SCG_SEL_AHB1 && reg_be == 4'hF
        |=> ahb1_reg == ($past(reg_wdata) & `SCG_AHB1_MASK);
    endproperty
    a_word_ahb1: assert property (p_word_ahb1)
        else $error("ahb1 word write");

    property p_word_ahb2;
        @(posedge ref_clk) disable iff (sys_rst)
        reg_wr && sel == SCG_SEL_AHB2 && reg_be == 4'hF
        |=> ahb2_reg == ($past(reg_wdata) & `SCG_AHB2_MASK);
    endproperty
    a_word_ahb2: assert property (p_word_ahb2)
        else $error("ahb2 word write");

    property p_word_apb1;
        @(posedge ref_clk) disable iff (sys_rst)
        reg_wr && sel == SCG_SEL_APB1 && reg_be == 4'hF
        |=> apb1_reg == ($past(reg_wdata) & `SCG_APB1_MASK);
    endproperty
    a_word_apb1: assert property (p_word_apb1)
        else $error("apb1 word write");

    property p_word_apb2;
        @(posedge ref_clk) disable iff (sys_rst)
        reg_wr && sel == SCG_SEL_APB2 && reg_be == 4'hF
        |=> apb2_reg == ($past(reg_wdata) & `SCG_APB2_MASK);
    endproperty
    a_word_apb2: assert property (p_word_apb2)
        else $error("apb2 word write");

    // a deselected byte lane keeps the third register's bits
    property p_lane_keep;
        @(posedge ref_clk) disable iff (sys_rst)
        reg_wr && sel == SCG_SEL_AHB3 && !reg_be[0] |=> $stable(ahb3_reg);
    endproperty
    a_lane_keep: assert property (p_lane_keep)
        else $error("ahb3 lane kept");

    // a set sleep bit leaves the clock to its run enable while asleep
    property p_sleep_keep;
        @(posedge ref_clk) disable iff (sys_rst)
        cpu_sleep && apb1_reg[`SCG_PWR_MGMT_BIT]
        |-> en_all[3*NGATE+`SCG_PWR_MGMT_BIT] ==
            apb1_run_en[`SCG_PWR_MGMT_BIT];
    endproperty
    a_sleep_keep: assert property (p_sleep_keep)
        else $error("sleep keep");

    // main scenarios reached
    c_sleep: cover property
        (@(posedge ref_clk) cpu_sleep && !apb1_reg[0]);
    c_wr_ahb2: cover property
        (@(posedge ref_clk) reg_wr && sel == SCG_SEL_AHB2);
    c_half: cover property
        (@(posedge ref_clk) reg_wr && reg_be == 4'h3);
    c_word: cover property
        (@(posedge ref_clk) reg_wr && reg_be == 4'hF);
    c_sleep_run: cover property
        (@(posedge ref_clk) cpu_sleep && apb2_reg[`SCG_RADIO_BIT]);
endmodule // scg_sleep_gating
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "scg_params.svh"
module tb_top;
    import scg_pkg::*;
    // ============================================================
    // signals and reference state
    logic              ref_clk;
    logic              sys_rst;
    logic              reg_wr;
    logic              reg_rd;
    logic [7:0]        reg_addr;
    logic [3:0]        reg_be;
    scg_word_t         reg_wdata;
    scg_word_t         reg_rdata;
    logic              reg_err;
    logic              cpu_sleep;
    logic [31:0]       run_en [5];
    logic [31:0]       gclk   [5];
    scg_word_t         mdl    [6];
    logic              rd_q;
    logic [31:0]       rng;
    logic [32:0]       exp_q [$];
    int                n_errors;
    int                checks_done;
    // index 5 is an unmapped offset between the third and fourth register
    localparam logic [7:0] OFF [6] = '{`SCG_AHB1_OFF, `SCG_AHB2_OFF,
        `SCG_AHB3_OFF, `SCG_APB1_OFF, `SCG_APB2_OFF, 8'h5C};
    localparam scg_word_t RST [6] = '{`SCG_AHB1_RST, `SCG_AHB2_RST,
        `SCG_AHB3_RST, `SCG_APB1_RST, `SCG_APB2_RST, 32'h0000_0000};
    localparam scg_word_t MSK [6] = '{`SCG_AHB1_MASK, `SCG_AHB2_MASK,
        `SCG_AHB3_MASK, `SCG_APB1_MASK, `SCG_APB2_MASK, 32'h0000_0000};

    scg_sleep_gating DUT
    (
        .ref_clk      (ref_clk),
        .sys_rst      (sys_rst),
        .reg_wr       (reg_wr),
        .reg_rd       (reg_rd),
        .reg_addr     (reg_addr),
        .reg_be       (reg_be),
        .reg_wdata    (reg_wdata),
        .reg_rdata    (reg_rdata),
        .reg_err      (reg_err),
        .cpu_sleep    (cpu_sleep),
        .ahb1_run_en  (run_en[0]),
        .ahb2_run_en  (run_en[1]),
        .ahb3_run_en  (run_en[2]),
        .apb1_run_en  (run_en[3]),
        .apb2_run_en  (run_en[4]),
        .ahb1_clk_out (gclk[0]),
        .ahb2_clk_out (gclk[1]),
        .ahb3_clk_out (gclk[2]),
        .apb1_clk_out (gclk[3]),
        .apb2_clk_out (gclk[4])
    );

    // ============================================================
    // clock, helpers and bus tasks
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        checks_done++;
        if (seen !== want)
        begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // one strobe cycle; write updates the reference image by byte lane
    task automatic bus(input logic w, input int i, input logic [3:0] be,
                       input scg_word_t d);
        scg_word_t m;
        @(posedge ref_clk);
        #1;
        reg_wr    = w;
        reg_rd    = ~w;
        reg_addr  = OFF[i];
        reg_be    = be;
        reg_wdata = d;
        exp_q.push_back({i == 5, w ? 32'h0000_0000 : mdl[i]});
        m = mdl[i];
        for (int j = 0; j < 4; j++)
            if (w && be[j])
                m[8*j +: 8] = d[8*j +: 8];
        mdl[i] = m & MSK[i];
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        #1;
        sys_rst = 1'b1;
        repeat (20) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        for (int i = 0; i < 6; i++)
            mdl[i] = RST[i];
    endtask

    // reads every register, reset values after a reset
    task automatic read_all();
        for (int i = 0; i < 6; i++)
            bus(1'b0, i, 4'h0, 32'h0000_0000);
    endtask

    // ============================================================
    // access monitor: oldest expectation against error flag and word
    always @(posedge ref_clk)
        rd_q <= reg_rd | reg_wr;

    always @(negedge ref_clk)
    begin
        if (rd_q)
        begin
            if (exp_q.size() == 0)
                check(33'h1_FFFF_FFFF, 33'h0_0000_0000);
            else
                check({reg_err, reg_rdata}, exp_q.pop_front());
        end
    end

    // bound on the whole run
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        summarize();
    end

    // ============================================================
    // main sequence
    initial
    begin
        logic [31:0] r;
        logic [31:0] gw;
        n_errors = 0;
        checks_done = 0;
        rng = 32'h0000_7B3C;
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_be = 4'h0;
        reg_wdata = 32'h0000_0000;
        cpu_sleep = 1'b0;
        for (int i = 0; i < 5; i++)
            run_en[i] = 32'h0000_0000;
        do_reset();
        read_all();
        $display("test reset values done");
        // random lanes and data, reserved bits kept clear by software
        repeat (60)
        begin
            r = xs() % 6;
            bus(1'b1, r, 4'(xs()), xs() & MSK[r]);
            bus(1'b0, r, 4'h0, 32'h0000_0000);
        end
        read_all();
        $display("test byte lane writes done");
        // gated clock seen in the high phase after the enable settles
        repeat (40)
        begin
            @(posedge ref_clk);
            #1;
            r = xs();
            cpu_sleep = r[0];
            for (int i = 0; i < 5; i++)
                run_en[i] = xs();
            r = xs() % 5;
            bus(1'b1, r, 4'hF, xs() & MSK[r]);
            repeat (2) @(posedge ref_clk);
            #1;
            for (int i = 0; i < 5; i++)
            begin
                gw = run_en[i] & ({32{~cpu_sleep}} | mdl[i]);
                check({1'b0, gclk[i]}, {1'b0, gw});
            end
            #2.5;
            for (int i = 0; i < 5; i++)
                check({1'b0, gclk[i]}, 33'h0_0000_0000);
        end
        $display("test sleep gating done");
        do_reset();
        read_all();
        $display("test second reset done");
        repeat (3) @(posedge ref_clk);
        summarize();
    end
endmodule // tb_top
`default_nettype wire
